/* src/ivm_pkg.sv */
// Purpose: Constants for the interrupt vector map
// Assumes: Word addresses are 16 bits wide
// Notes:   Vector numbers count from one; vector 1 is the reset vector
package ivm_pkg;
   localparam int          IVM_NUM_VEC     = 20;
   localparam int          IVM_NUM_IRQ     = 19;
   localparam int          IVM_ADDR_W      = 16;
   localparam int          IVM_VEC_W       = 5;
   localparam logic [15:0] IVM_RESET_ADDR  = 16'h0000;
   localparam logic [15:0] IVM_LAST_SMALL  = 16'h0013;
   localparam logic [15:0] IVM_LAST_LARGE  = 16'h0026;
   localparam logic [15:0] IVM_MAIN_SMALL  = 16'h0014;
   localparam logic [4:0]  IVM_RESET_VEC   = 5'h01;
   localparam logic [4:0]  IVM_FIRST_IRQ   = 5'h02;
   // Request bit positions, bit k is vector k+2
   localparam int IVM_EXT0   = 0;
   localparam int IVM_EXT1   = 1;
   localparam int IVM_PCLOW  = 2;
   localparam int IVM_PCHIGH = 3;
   localparam int IVM_WDOG   = 4;
   localparam int IVM_TB_CAP = 5;
   localparam int IVM_TB_MA  = 6;
   localparam int IVM_TB_MB  = 7;
   localparam int IVM_TB_OVF = 8;
   localparam int IVM_TA_MA  = 9;
   localparam int IVM_TA_OVF = 10;
   localparam int IVM_LIN_DONE_IRQ = 11;
   localparam int IVM_LIN_ER = 12;
   localparam int IVM_SPI    = 13;
   localparam int IVM_ADC    = 14;
   localparam int IVM_EE_RDY = 15;
   localparam int IVM_ACMP   = 16;
   localparam int IVM_SER_ST = 17;
   localparam int IVM_SER_WR = 18;
endpackage

/* src/ivm_vec_addr.sv */
// Purpose: Converts a vector number to its program word address
// Assumes: Vector number in range 1..20
// Notes:   Pure combinational, used by the main block
`timescale 1ns/100ps
`default_nettype none
module ivm_vec_addr
   import ivm_pkg::*;
(
   // Select
   input  wire logic                  large_i,
   input  wire logic [IVM_VEC_W-1:0]  vec_i,
   // Address
   output logic      [IVM_ADDR_W-1:0] addr_o
);
   logic [IVM_ADDR_W-1:0] slot;

   always_comb begin
      slot = {{(IVM_ADDR_W-IVM_VEC_W){1'b0}}, vec_i - IVM_RESET_VEC};
      if (large_i) begin
         addr_o = {slot[IVM_ADDR_W-2:0], 1'b0}; // RQ4
      end else begin
         addr_o = slot; // RQ3
      end
   end
endmodule
`default_nettype wire

/* src/ivm_top.sv */
// Purpose: Picks the pending request and presents its vector address
// Assumes: Requests and reset sources are levels synchronous to clk_sys_i
// Notes:   Core holds ack_i high each cycle it takes the vector; reset wins
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RQ1] Every reset source goes to vector 1 at word address 0x0000.
// [RQ2] Vectors 6 to 20 follow the fixed peripheral order.
// [RQ3] Small variant: vector n at word n-1, last at 0x0013.
// [RQ4] Large variant: vector n at word 2(n-1), last at 0x0026.
// [RQ5] External 0/1 and pin change low/high take vectors 2 to 5.
// [RQ6] Software puts one jump per slot; main code starts at 0x0014.
// [RQ7] Of several pending requests the lowest vector number wins.
module ivm_top
   import ivm_pkg::*;
#(
   parameter bit LARGE_FLASH = 1'b0
)(
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   sys_rst_i,
   // Reset sources
   input  wire logic                   rst_pin_i,
   input  wire logic                   rst_por_i,
   input  wire logic                   rst_bod_i,
   input  wire logic                   rst_wdog_i,
   // Interrupt requests
   input  wire logic                   ext_request_zero_i,
   input  wire logic                   ext_request_one_i,
   input  wire logic                   pin_change_group_low_i,
   input  wire logic                   pin_change_group_high_i,
   input  wire logic                   watchdog_timeout_irq_i,
   input  wire logic                   timer_b_capture_irq_i,
   input  wire logic                   timer_b_match_a_irq_i,
   input  wire logic                   timer_b_match_b_irq_i,
   input  wire logic                   timer_b_overflow_irq_i,
   input  wire logic                   timer_a_match_irq_i,
   input  wire logic                   timer_a_overflow_irq_i,
   input  wire logic                   lin_done_irq_i,
   input  wire logic                   lin_error_irq_i,
   input  wire logic                   spi_done_irq_i,
   input  wire logic                   adc_done_irq_i,
   input  wire logic                   eeprom_ready_irq_i,
   input  wire logic                   comparator_irq_i,
   input  wire logic                   serial_start_detect_irq_i,
   input  wire logic                   serial_counter_wrap_irq_i,
   // Core side
   input  wire logic                   ack_i,
   output logic                        vec_valid_o,
   output logic      [IVM_VEC_W-1:0]   vec_num_o,
   output logic      [IVM_ADDR_W-1:0]  vec_addr_o,
   output logic      [IVM_NUM_IRQ-1:0] ack_onehot_o
);
   logic [IVM_NUM_IRQ-1:0] req;
   logic                   any_rst;
   logic                   next_valid;
   logic [IVM_VEC_W-1:0]   next_num;
   logic [IVM_ADDR_W-1:0]  next_addr;

   // Lowest set bit gives the lowest vector number
   function automatic logic [IVM_VEC_W-1:0] ivm_pick(
      input logic [IVM_NUM_IRQ-1:0] r);
      logic [IVM_VEC_W-1:0] v;
      v = '0;
      for (int k = IVM_NUM_IRQ-1; k >= 0; k--) begin
         if (r[k]) begin
            v = IVM_VEC_W'(k) + IVM_FIRST_IRQ; // RQ7
         end
      end
      return v;
   endfunction

   always_comb begin
      req = '0;
      req[IVM_EXT0]   = ext_request_zero_i; // RQ5
      req[IVM_EXT1]   = ext_request_one_i;
      req[IVM_PCLOW]  = pin_change_group_low_i;
      req[IVM_PCHIGH] = pin_change_group_high_i;
      req[IVM_WDOG]   = watchdog_timeout_irq_i; // RQ2
      req[IVM_TB_CAP] = timer_b_capture_irq_i;
      req[IVM_TB_MA]  = timer_b_match_a_irq_i;
      req[IVM_TB_MB]  = timer_b_match_b_irq_i;
      req[IVM_TB_OVF] = timer_b_overflow_irq_i;
      req[IVM_TA_MA]  = timer_a_match_irq_i;
      req[IVM_TA_OVF] = timer_a_overflow_irq_i;
      req[IVM_LIN_DONE_IRQ] = lin_done_irq_i;
      req[IVM_LIN_ER] = lin_error_irq_i;
      req[IVM_SPI]    = spi_done_irq_i;
      req[IVM_ADC]    = adc_done_irq_i;
      req[IVM_EE_RDY] = eeprom_ready_irq_i;
      req[IVM_ACMP]   = comparator_irq_i;
      req[IVM_SER_ST] = serial_start_detect_irq_i;
      req[IVM_SER_WR] = serial_counter_wrap_irq_i;
   end

   assign any_rst = rst_pin_i | rst_por_i | rst_bod_i | rst_wdog_i;

   always_comb begin
      if (any_rst) begin
         next_valid = 1'b1;
         next_num   = IVM_RESET_VEC; // RQ1
      end else begin
         next_valid = |req;
         next_num   = ivm_pick(req);
      end
   end

   ivm_vec_addr u_addr (
      .large_i (LARGE_FLASH),
      .vec_i   (next_num),
      .addr_o  (next_addr)
   );

   // Registered so the core sees a stable vector for a whole cycle
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         vec_valid_o <= 1'b1;
         vec_num_o   <= IVM_RESET_VEC;
         vec_addr_o  <= IVM_RESET_ADDR; // RQ1
      end else begin
         vec_valid_o <= next_valid;
         vec_num_o   <= next_valid ? next_num : '0;
         vec_addr_o  <= next_valid ? next_addr : IVM_RESET_ADDR;
      end
   end

   // Tells the source whose vector the core took, to clear its flag
   always_comb begin
      ack_onehot_o = '0;
      if (ack_i && vec_valid_o && vec_num_o >= IVM_FIRST_IRQ) begin
         ack_onehot_o[vec_num_o - IVM_FIRST_IRQ] = 1'b1;
      end
   end

   // Helper copy of the requests, so the priority check does not reuse
   // the picking function it is meant to judge
   logic [IVM_NUM_IRQ-1:0] req_q;
   logic [IVM_NUM_IRQ-1:0] below_mask;

   always_ff @(posedge clk_sys_i) begin
      req_q <= req;
   end

   // Bits below the presented request; all ones when none is presented
   always_comb begin
      below_mask = (IVM_NUM_IRQ'(1) << (vec_num_o - IVM_FIRST_IRQ))
                   - IVM_NUM_IRQ'(1);
   end

   reset_addr_a: assert property ( // RQ1
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      any_rst |=> vec_valid_o && vec_addr_o == IVM_RESET_ADDR)
      else $error("reset source did not map to address zero");
   last_addr_a: assert property ( // RQ3 RQ4
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && serial_counter_wrap_irq_i && req[IVM_SER_WR-1:0] == '0
      |=> vec_addr_o == (LARGE_FLASH ? IVM_LAST_LARGE : IVM_LAST_SMALL))
      else $error("last vector address wrong");
   ext0_first_a: assert property ( // RQ5
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && ext_request_zero_i |=> vec_num_o == 5'h02)
      else $error("external request zero not vector 2");
   ext0_addr_a: assert property ( // RQ5
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && ext_request_zero_i
      |=> vec_addr_o == (LARGE_FLASH ? 16'h0002 : 16'h0001))
      else $error("external request zero at wrong address");
   ext1_vec_a: assert property ( // RQ5
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && ext_request_one_i && req[0] == 1'b0 |=> vec_num_o == 5'h03)
      else $error("external request one not vector 3");
   pcl_vec_a: assert property ( // RQ5
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && pin_change_group_low_i && req[1:0] == '0
      |=> vec_num_o == 5'h04)
      else $error("pin change low not vector 4");
   pch_vec_a: assert property ( // RQ5
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && pin_change_group_high_i && req[2:0] == '0
      |=> vec_num_o == 5'h05
          && vec_addr_o == (LARGE_FLASH ? 16'h0008 : 16'h0004))
      else $error("pin change high not vector 5");
   wdog_vec_a: assert property ( // RQ2
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && watchdog_timeout_irq_i && req[3:0] == '0
      |=> vec_num_o == 5'h06)
      else $error("watchdog not vector 6");
   prio_low_a: assert property ( // RQ7
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && req != '0
      |=> vec_num_o >= IVM_FIRST_IRQ && req_q[vec_num_o - IVM_FIRST_IRQ]
          && (req_q & below_mask) == '0)
      else $error("not lowest vector");
   idle_a: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !any_rst && req == '0 |=> !vec_valid_o)
      else $error("valid without request");
   num_range_a: assert property ( // RQ2
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      vec_valid_o |-> vec_num_o >= IVM_RESET_VEC && vec_num_o <= 5'h14)
      else $error("vector number outside the table");
   addr_form_a: assert property ( // RQ3 RQ4
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      vec_valid_o |-> vec_addr_o == (LARGE_FLASH ?
         16'((vec_num_o - 5'h01) * 2) : 16'(vec_num_o - 5'h01)))
      else $error("address not derived from vector");
   ack_one_a: assert property (
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      $countones(ack_onehot_o) <= 1)
      else $error("more than one acknowledge");

   reset_c: cover property (@(posedge clk_sys_i) any_rst);
   multi_c: cover property (@(posedge clk_sys_i)
      !any_rst && $countones(req) > 1);
   last_c:  cover property (@(posedge clk_sys_i) vec_num_o == 5'h14);
   ack_c:   cover property (@(posedge clk_sys_i) ack_onehot_o != '0);
   idle_c:  cover property (@(posedge clk_sys_i) !vec_valid_o);
endmodule
`default_nettype wire

/* verification/ivm_core_model.sv */
// Purpose: Core model that takes each presented vector
// Assumes: Takes one vector a cycle while enabled
// Notes:   Flags a small-table slot that runs into main code
`timescale 1ns/100ps
`default_nettype none
module ivm_core_model
   import ivm_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  sys_rst_i,
   // Vector side
   input  wire logic                  en_i,
   input  wire logic                  vec_valid_i,
   input  wire logic [IVM_ADDR_W-1:0] vec_addr_i,
   output logic                       ack_o,
   output logic                       slot_bad_o
);
   // Level ack: an enabled core takes the vector each cycle
   always_ff @(negedge clk_sys_i) begin
      ack_o <= en_i & vec_valid_i;
   end
   // One jump per slot, so no slot may reach main code
   always_ff @(negedge clk_sys_i) begin
      if (sys_rst_i) begin
         slot_bad_o <= 1'b0;
      end else if (vec_valid_i && vec_addr_i >= IVM_MAIN_SMALL) begin
         slot_bad_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for the vector map
// Assumes: Inputs change at the falling edge
// Notes:   Second instance covers the two-word spacing
`timescale 1ns/100ps
`default_nettype none
module tb
   import ivm_pkg::*;
;
   logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, en = 1'b0;
   logic [3:0]  rsrc = 4'h0;
   logic [18:0] req = 19'h0;
   logic        ack_i, vec_valid_o, slot_bad;
   logic [4:0]  vec_num_o;
   logic [15:0] vec_addr_o, addr_l;
   logic [18:0] ack_onehot_o;
   int          err_total = 0, num_checks = 0;
   wire logic rst_pin_i = rsrc[0], rst_por_i = rsrc[1], rst_bod_i = rsrc[2],
      rst_wdog_i = rsrc[3], ext_request_zero_i = req[0],
      ext_request_one_i = req[1], pin_change_group_low_i = req[2],
      pin_change_group_high_i = req[3], watchdog_timeout_irq_i = req[4],
      timer_b_capture_irq_i = req[5], timer_b_match_a_irq_i = req[6],
      timer_b_match_b_irq_i = req[7], timer_b_overflow_irq_i = req[8],
      timer_a_match_irq_i = req[9], timer_a_overflow_irq_i = req[10],
      lin_done_irq_i = req[11], lin_error_irq_i = req[12],
      spi_done_irq_i = req[13], adc_done_irq_i = req[14],
      eeprom_ready_irq_i = req[15], comparator_irq_i = req[16],
      serial_start_detect_irq_i = req[17],
      serial_counter_wrap_irq_i = req[18];
   ivm_top dut (.*);
   ivm_top #(.LARGE_FLASH(1'b1)) dut_l (.vec_addr_o(addr_l), .vec_valid_o(),
      .vec_num_o(), .ack_onehot_o(), .*);
   ivm_core_model core (.clk_sys_i, .sys_rst_i, .en_i(en),
      .vec_valid_i(vec_valid_o), .vec_addr_i(vec_addr_o), .ack_o(ack_i),
      .slot_bad_o(slot_bad));
   always #10 clk_sys_i = ~clk_sys_i;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic settle(input logic [3:0] s, input logic [18:0] r);
      @(negedge clk_sys_i) begin
         rsrc = s;
         req = r;
      end
      @(negedge clk_sys_i) #1;
   endtask
   task automatic t_resets();
      for (int s = 0; s < 4; s++) begin
         settle(4'h1 << s, 19'h7ffff);
         chk({vec_num_o, vec_addr_o}, {IVM_RESET_VEC, IVM_RESET_ADDR});
         chk({addr_l, ack_onehot_o}, 24'h0);
      end
   endtask
   task automatic t_vectors();
      for (int k = 0; k < IVM_NUM_IRQ; k++) begin
         settle(4'h0, 19'h1 << k);
         chk(vec_num_o, 24'(k + 2));
         chk(vec_addr_o, 24'(k + 1));
         chk(addr_l, 24'(2 * (k + 1)));
         chk(ack_onehot_o, req);
      end
      chk(vec_addr_o, IVM_LAST_SMALL);
      chk(addr_l, IVM_LAST_LARGE);
   endtask
   task automatic t_prio();
      for (int k = 0; k < IVM_NUM_IRQ; k++) begin
         settle(4'h0, 19'h7ffff << k);
         chk(vec_num_o, 24'(k + 2));
      end
      settle(4'h0, 19'h0);
      chk({vec_valid_o, vec_addr_o}, 24'h0);
   endtask
   // Core not taking the vector: no source may be told to clear
   task automatic t_no_ack();
      en = 1'b0;
      settle(4'h0, 19'h1);
      chk(ack_onehot_o, 19'h0);
      chk(vec_num_o, 5'h02);
      en = 1'b1;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk_sys_i);
      chk(vec_num_o, IVM_RESET_VEC);
      sys_rst_i = 1'b0;
      en = 1'b1;
      t_resets();
      t_vectors();
      t_prio();
      t_no_ack();
      chk(slot_bad, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
